// *** acs_cmd_rx.sv ***
// acs_cmd_rx: serial start and stop command decoder on the link clock
`timescale 1ns/1ps
module acs_cmd_rx (
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  output logic      start_tgl,
  output logic      stop_tgl
);
  import acs_pkg::*;

  logic [5:0] edge_cnt_r;
  logic [7:0] shift_r;
  // power-up value: the link clock may never run before the first frame
  logic       start_tgl_r = 1'b0;
  logic       stop_tgl_r  = 1'b0;

  // ----------------------------------------------------------------
  // frame bookkeeping
  // ----------------------------------------------------------------
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      edge_cnt_r <= 6'h00;
    end else if (edge_cnt_r != EDGE_SAT) begin
      edge_cnt_r <= edge_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n && edge_cnt_r < CMD_BITS) begin
      shift_r <= {shift_r[6:0], sdi};
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire act_edge = !cs_n && (edge_cnt_r == CMD_EDGE);

  // events cross as toggles, the system side compares synchronised copies
  always_ff @(negedge sclk) begin
    if (act_edge && shift_r == CMD_START) begin
      start_tgl_r <= ~start_tgl_r; // RULE3
    end
    if (act_edge && shift_r == CMD_STOP) begin
      stop_tgl_r <= ~stop_tgl_r; // RULE3
    end
  end

  assign start_tgl = start_tgl_r;
  assign stop_tgl  = stop_tgl_r;

  // no disable on cs_n: the next falling edge only comes in the following frame
  a_cmd_on_32nd: assert property (@(negedge sclk) // RULE3
    (!cs_n && edge_cnt_r == CMD_EDGE && shift_r == CMD_START) |=> (start_tgl_r != $past(start_tgl_r)))
    else $error("start command not taken on 32nd falling edge");

  a_no_early_cmd: assert property (@(negedge sclk) disable iff (cs_n) // RULE3
    (edge_cnt_r < CMD_EDGE) |=> (stop_tgl_r == $past(stop_tgl_r)))
    else $error("stop command taken before 32nd falling edge");

endmodule

// *** acs_host_model.sv ***
// acs_host_model: host driving the start pin and the serial command port
`timescale 1ns/1ps
module acs_host_model (
  input  wire logic clk_sys,
  output logic      start_pin,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi
);
  initial begin
    start_pin = 1'b0;
    sclk      = 1'b0;
    cs_n      = 1'b1;
    sdi       = 1'b0;
  end
  // ----------------------------------------------------------------
  // start pin, moved just after a system edge
  // ----------------------------------------------------------------
  task automatic set_pin(input logic v);
    @(posedge clk_sys);
    #1 start_pin = v;
  endtask
  // ----------------------------------------------------------------
  // one 32 clock frame, msb first; sclk idles low between frames
  // ----------------------------------------------------------------
  // pin is kept low by the caller while commands run the converter
  task automatic send_cmd(input logic [7:0] cmd);
    int i;
    #7 cs_n = 1'b0;
    for (i = 0; i < 32; i++) begin
      sdi = (i < 8) ? cmd[7 - i] : i[0];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    sdi = ~sdi; // released line shows no stale level
  endtask
endmodule

// *** acs_pkg.sv ***
// acs_pkg: constants, carriers and timing tables of the conversion sequencer
package acs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned DELAY_DEF_US   = 50;
  localparam int unsigned DELAY_DEF_NS   = DELAY_DEF_US * 1000;
  localparam logic [3:0]  DELAY_DEF_CODE = 4'h1;
  localparam int unsigned NUM_RATES      = 17;
  localparam logic [4:0]  RATE_MAX       = 5'h10;
  localparam logic [4:0]  RATE_SINC5_MIN = 5'h0d;

  // conversion period 1/output_sample_rate per rate code, ns
  localparam int unsigned PERIOD_NS [NUM_RATES] = '{
    400000000, 200000000, 100000000, 60000000, 50000000, 20000000, 16666667,
    10000000, 2500000, 833333, 416667, 208333, 138889, 69444, 52083, 39063, 25000};

  // first_result_latency of sinc1 (sinc5 for the four top rates), ns
  localparam int unsigned LAT1_NS [NUM_RATES] = '{
    400400000, 200400000, 100400000, 60430000, 50430000, 20430000, 17090000,
    10430000, 2925000, 1258000, 841000, 633000, 564000, 423000, 336000, 271000, 179000};

  // first_result_latency of the fir filter, rate codes 0, 1, 2 and 4 only
  localparam int unsigned FIR_NS [4] = '{402200000, 202200000, 102200000, 52220000};

  // ----------------------------------------------------------------
  // configuration encodings
  // ----------------------------------------------------------------
  localparam int          MODE_BIT   = 4;
  localparam logic [2:0]  FILT_SINC5 = 3'h4;
  localparam logic [2:0]  FILT_FIR   = 3'h5;
  localparam logic [7:0]  CMD_START  = 8'h08;
  localparam logic [7:0]  CMD_STOP   = 8'h0a;
  localparam logic [5:0]  CMD_EDGE   = 6'h1f;
  localparam logic [5:0]  EDGE_SAT   = 6'h20;
  localparam logic [5:0]  CMD_BITS   = 6'h08;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       auto_zero;
    logic [2:0] filter;
    logic [4:0] rate;
    logic [3:0] delay;
  } acs_cfg_type;

  typedef struct packed {
    logic busy;
    logic filter_run;
    logic filter_clear;
    logic chop_invert;
    logic conv_done;
  } acs_stat_type;

endpackage

// *** acs_sequencer.sv ***
// acs_sequencer: start, stop and timing of conversions with result ready output
//
// Notes on behaviour
// RULE1: start pin or serial commands start and stop
// RULE2: host keeps start pin low using commands
// RULE3: commands act at 32nd falling serial edge
// RULE4: setup bit four picks continuous or pulse
// RULE5: continuous mode converts back to back until stopped
// RULE6: ready high at begin, low at result
// RULE7: continuous stop lets running conversion finish
// RULE8: retoggle or new start restarts conversion
// RULE9: pulse mode: one conversion per trigger
// RULE10: pulse mode stop never cuts conversion short
// RULE11: fir and sinc1 settle in one cycle
// RULE12: first latency includes delay; then data period
// RULE13: first latency follows filter and rate table
// RULE14: auto zero doubles first latency
// RULE15: host discards unsettled results after input change
// RULE16: programmable start delay, default code 0001
// RULE17: auto zero alternates polarity, period equals latency
// RULE18: start pin high after reset starts conversion
// RULE19: restart clears partial filter state
// RULE20: times counted in modulator clock cycles
`timescale 1ns/1ps
module acs_sequencer #(
  parameter int unsigned TIME_DIV = 1
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic                  start_pin,
  input  wire logic                  sclk,
  input  wire logic                  cs_n,
  input  wire logic                  sdi,
  input  wire logic [7:0]            conversion_setup_register,
  input  wire acs_pkg::acs_cfg_type  cfg,
  output logic                       result_ready_n,
  output acs_pkg::acs_stat_type      stat
);
  import acs_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_FILTER
  } acs_state_type;

  // ----------------------------------------------------------------
  // timing functions
  // ----------------------------------------------------------------
  // all times round down, never below one cycle; TIME_DIV shortens all
  function automatic logic [31:0] cyc_of(input logic [31:0] ns);
    logic [31:0] c;
    c = (ns / CLK_PERIOD_NS) / TIME_DIV;
    return (c == 32'h0000_0000) ? 32'h0000_0001 : c;
  endfunction

  function automatic logic [4:0] rate_idx(input logic [4:0] r);
    return (r > RATE_MAX) ? RATE_MAX : r;
  endfunction

  function automatic logic [31:0] period_ns(input logic [4:0] r);
    return 32'(PERIOD_NS[rate_idx(r)]);
  endfunction

  // table latency: below RATE_SINC5_MIN, sinc order n up to 4 adds n-1 periods to sinc1; sinc5 takes the sinc1 table value
  function automatic logic [31:0] lat_ns(input logic [4:0] r, input logic [2:0] f);
    logic [4:0] i;
    i = rate_idx(r);
    if (f == FILT_FIR && i < 5'h05 && i != 5'h03) begin
      return 32'(FIR_NS[(i == 5'h04) ? 2'h3 : i[1:0]]); // RULE11
    end
    if (i >= RATE_SINC5_MIN || f >= FILT_SINC5) begin
      return 32'(LAT1_NS[i]); // RULE13
    end
    return 32'(LAT1_NS[i]) + 32'(f) * period_ns(i); // RULE13
  endfunction

  // delay code 0 is none, code n is 50 us doubled n-1 times
  function automatic logic [31:0] delay_ns(input logic [3:0] code);
    return (code == 4'h0) ? 32'h0000_0000 : (32'(DELAY_DEF_NS) << (code - DELAY_DEF_CODE));
  endfunction

  // ----------------------------------------------------------------
  // start pin synchroniser
  // ----------------------------------------------------------------
  logic start_meta_r;
  logic start_sync_r;
  logic start_prev_r;

  // prev resets low, so a pin already high after reset reads as a rise
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      start_meta_r <= 1'b0;
      start_sync_r <= 1'b0;
      start_prev_r <= 1'b0;
    end else begin
      start_meta_r <= start_pin;
      start_sync_r <= start_meta_r;
      start_prev_r <= start_sync_r;
    end
  end

  wire pin_rise = start_sync_r && !start_prev_r; // RULE18
  wire pin_fall = !start_sync_r && start_prev_r;

  // ----------------------------------------------------------------
  // serial command crossing
  // ----------------------------------------------------------------
  logic       start_tgl;
  logic       stop_tgl;
  logic [1:0] tgl_meta_r;
  logic [1:0] tgl_sync_r;
  logic [1:0] tgl_prev_r;

  acs_cmd_rx u_cmd_rx (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .sdi       (sdi),
    .start_tgl (start_tgl),
    .stop_tgl  (stop_tgl)
  );

  always_ff @(posedge clk_sys) begin
    tgl_meta_r <= {stop_tgl, start_tgl};
    tgl_sync_r <= tgl_meta_r;
    tgl_prev_r <= srst ? tgl_sync_r : tgl_prev_r ^ (tgl_sync_r ^ tgl_prev_r);
  end

  wire [1:0] cmd_evt  = srst ? 2'h0 : (tgl_sync_r ^ tgl_prev_r);
  wire       start_evt = pin_rise || cmd_evt[0]; // RULE1
  wire       stop_evt  = pin_fall || cmd_evt[1]; // RULE1

  // ----------------------------------------------------------------
  // cycle counts for the present configuration
  // ----------------------------------------------------------------
  wire        pulse_mode = conversion_setup_register[MODE_BIT]; // RULE4
  wire [31:0] lat_cyc    = cyc_of(lat_ns(cfg.rate, cfg.filter) - 32'(DELAY_DEF_NS)); // RULE12
  wire [31:0] dly_cyc    = cyc_of(delay_ns(cfg.delay)); // RULE16 RULE20
  wire [31:0] first_cyc  = cfg.auto_zero ? {lat_cyc[30:0], 1'b0} : lat_cyc; // RULE14
  // auto zero pairs conversions, so the output rate is one per latency
  wire [31:0] next_cyc   = cfg.auto_zero ? cyc_of(lat_ns(cfg.rate, cfg.filter)) // RULE17
                                         : cyc_of(period_ns(cfg.rate)); // RULE12

  // ----------------------------------------------------------------
  // conversion state machine
  // ----------------------------------------------------------------
  acs_state_type state_r;
  acs_state_type state_nxt;
  logic [31:0]   cnt_r;
  logic [31:0]   cnt_nxt;
  logic          run_r;
  logic          run_nxt;
  logic          rdy_n_r;
  logic          rdy_n_nxt;
  logic          clear_r;
  logic          clear_nxt;
  logic          done_r;
  logic          done_nxt;
  logic          chop_r;
  logic          chop_nxt;

  wire cnt_zero = (cnt_r == 32'h0000_0000);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_zero ? cnt_r : cnt_r - 32'h0000_0001;
    run_nxt   = run_r;
    rdy_n_nxt = rdy_n_r;
    clear_nxt = 1'b0;
    done_nxt  = 1'b0;
    chop_nxt  = chop_r;
    if (start_evt) begin
      // restart abandons whatever runs and wipes the filter
      state_nxt = ST_DELAY; // RULE8
      cnt_nxt   = dly_cyc - 32'h0000_0001; // RULE16
      run_nxt   = !pulse_mode; // RULE5 RULE9
      rdy_n_nxt = 1'b1; // RULE6
      clear_nxt = 1'b1; // RULE19
      chop_nxt  = 1'b0;
    end else begin
      if (stop_evt) begin
        run_nxt = 1'b0; // RULE7 RULE10
      end
      case (state_r)
        ST_IDLE: begin
          run_nxt = 1'b0;
        end
        ST_DELAY: begin
          if (cnt_zero) begin
            state_nxt = ST_FILTER;
            cnt_nxt   = first_cyc - 32'h0000_0001; // RULE12 RULE14
          end
        end
        ST_FILTER: begin
          rdy_n_nxt = 1'b1; // RULE6
          if (cnt_zero) begin
            rdy_n_nxt = 1'b0; // RULE6
            done_nxt  = 1'b1;
            chop_nxt  = cfg.auto_zero ? !chop_r : 1'b0; // RULE17
            if (run_r && !stop_evt && !pulse_mode) begin
              cnt_nxt = next_cyc - 32'h0000_0001; // RULE5 RULE12
            end else begin
              state_nxt = ST_IDLE; // RULE7 RULE9
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
      cnt_r   <= 32'h0000_0000;
      run_r   <= 1'b0;
      rdy_n_r <= 1'b1;
      clear_r <= 1'b0;
      done_r  <= 1'b0;
      chop_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      run_r   <= run_nxt;
      rdy_n_r <= rdy_n_nxt;
      clear_r <= clear_nxt;
      done_r  <= done_nxt;
      chop_r  <= chop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign result_ready_n = rdy_n_r;
  // one driver for the whole carrier, fields never split across assigns
  assign stat = '{busy:         (state_r != ST_IDLE),
                  filter_run:   (state_r == ST_FILTER),
                  filter_clear: clear_r,
                  chop_invert:  chop_r,
                  conv_done:    done_r};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence seq_restart;
    start_evt ##1 (state_r == ST_DELAY && clear_r && rdy_n_r);
  endsequence

  sequence seq_finish;
    state_r == ST_FILTER && cnt_zero && !start_evt;
  endsequence

  a_restart_clears: assert property (start_evt |-> seq_restart) // RULE8
    else $error("start did not restart with cleared filter");

  a_clear_on_start: assert property (clear_r |-> $past(start_evt)) // RULE19
    else $error("filter clear without a start");

  a_delay_load: assert property (start_evt |=> cnt_r == $past(dly_cyc) - 32'h0000_0001) // RULE16
    else $error("start delay count wrong");

  a_first_latency: assert property ((state_r == ST_DELAY && cnt_zero && !start_evt) // RULE14
    |=> state_r == ST_FILTER && cnt_r == $past(first_cyc) - 32'h0000_0001)
    else $error("first conversion count wrong");

  a_ready_low_done: assert property (seq_finish |=> !rdy_n_r && done_r) // RULE6
    else $error("result ready not low at completion");

  a_cont_repeat: assert property ((seq_finish and (run_r && !stop_evt && !pulse_mode)) // RULE5
    |=> state_r == ST_FILTER && cnt_r == $past(next_cyc) - 32'h0000_0001 ##1 rdy_n_r)
    else $error("continuous conversion did not repeat");

  a_pulse_stops: assert property ((seq_finish and pulse_mode) |=> state_r == ST_IDLE) // RULE9
    else $error("pulse mode kept converting");

  a_stop_finishes: assert property ((stop_evt && !start_evt && state_r == ST_FILTER && !cnt_zero) // RULE7
    |=> state_r == ST_FILTER && !run_r)
    else $error("stop cut a running conversion");

  a_reset_start: assert property ($rose(start_sync_r) |-> start_evt) // RULE18
    else $error("high start pin did not start conversion");

  a_fir_single: assert property ((cfg.filter == FILT_FIR && cfg.rate == 5'h04 && !cfg.auto_zero) // RULE11
    |-> lat_cyc == cyc_of(32'(FIR_NS[3]) - 32'(DELAY_DEF_NS)))
    else $error("fir latency not single cycle");

endmodule

// *** test_acs_sequencer.sv ***
// test_acs_sequencer: directed tests of start, stop, restart and latency
`timescale 1ns/1ps
module test_acs_sequencer;
  import acs_pkg::*;
  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  // large divider keeps the longest latency near a few hundred cycles
  localparam int unsigned TD = 10000;
  // rate 5'h1f exercises the clamp to the top rate, delay 0 the no-delay code
  localparam logic [2:0] T_FILT [6] = '{FILT_FIR, 3'h0, FILT_SINC5, 3'h0, 3'h1, 3'h3};
  localparam logic [4:0] T_RATE [6] = '{5'h04, 5'h04, 5'h1f, 5'h04, 5'h04, 5'h0b};
  localparam logic       T_AZ   [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam logic [3:0] T_DLY  [6] = '{4'h1, 4'h1, 4'h0, 4'h9, 4'h1, 4'h6};
  localparam int         T_LAT  [6] = '{FIR_NS[3], LAT1_NS[4], LAT1_NS[16], LAT1_NS[4],
                                        LAT1_NS[4] + PERIOD_NS[4], 1_258_000};
  logic         clk_sys;
  logic         srst;
  logic         start_pin;
  logic         sclk;
  logic         cs_n;
  logic         sdi;
  logic [7:0]   conversion_setup_register;
  acs_cfg_type  cfg;
  logic         result_ready_n;
  acs_stat_type stat;
  int           n_mismatch;
  int           samples_checked;
  int           cyc_now;
  int           t_mark;
  int           n;
  int           le;
  logic         seen_hi;

  acs_sequencer #(.TIME_DIV(TD)) acs_sequencer_inst (
    .clk_sys(clk_sys), .srst(srst), .start_pin(start_pin), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .conversion_setup_register(conversion_setup_register), .cfg(cfg),
    .result_ready_n(result_ready_n), .stat(stat));
  acs_host_model acs_host_model_inst (
    .clk_sys(clk_sys), .start_pin(start_pin), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc_now++;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int cyc(input longint ns);
    cyc = (ns / 20 / TD > 0) ? int'(ns / 20 / TD) : 1;
  endfunction
  // pin rise to ready low: sync and launch edges, delay, filter
  function automatic int lat_exp(input logic [3:0] d, input int lat_ns, input logic az);
    lat_exp = 4 + cyc(d == 4'h0 ? 0 : longint'(50000) << (d - 4'h1))
            + cyc(lat_ns - 50000) * (az ? 2 : 1);
  endfunction
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic check_near(input int got, input int exp, input string what);
    samples_checked++;
    if (got < exp - 2 || got > exp + 2) begin
      n_mismatch++;
      $display("ERROR %0t: %s took %0d cycles, exp %0d", $time, what, got, exp);
    end
  endtask
  // cycles from the mark to the next ready fall; the fall becomes the mark
  task automatic wait_conv;
    int k;
    seen_hi = 1'b0;
    for (k = 0; k < 3000 && !(seen_hi && result_ready_n === 1'b0); k++) begin
      tick();
      if (result_ready_n === 1'b1) seen_hi = 1'b1;
    end
    check_bit(seen_hi, 1'b1, "ready high in conversion");
    check_bit(stat.conv_done, 1'b1, "done with ready fall");
    n = cyc_now - t_mark;
    t_mark = cyc_now;
  endtask
  task automatic quiet(input int cycles);
    seen_hi = 1'b0;
    repeat (cycles) begin
      tick();
      if (result_ready_n !== 1'b0) seen_hi = 1'b1;
    end
  endtask
  task automatic pin_start;
    acs_host_model_inst.set_pin(1'b0);
    repeat (5) tick();
    acs_host_model_inst.set_pin(1'b1);
    t_mark = cyc_now;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    n_mismatch++;
    $display("ERROR %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    cyc_now = 0;
    srst = 1'b1;
    conversion_setup_register = 8'hff;
    cfg = '{auto_zero: 1'b0, filter: 3'h0, rate: 5'h04, delay: DELAY_DEF_CODE};
    le = lat_exp(DELAY_DEF_CODE, LAT1_NS[4], 1'b0);
    acs_host_model_inst.set_pin(1'b1);
    tick();
    check_bit(result_ready_n, 1'b1, "ready in reset");
    tick();
    srst = 1'b0;
    t_mark = cyc_now;
    wait_conv();
    check_near(n, le, "start held through reset");
    quiet(150);
    check_bit(seen_hi, 1'b0, "pulse mode second conversion");
    pin_start();
    repeat (3) tick();
    check_bit(stat.filter_clear, 1'b1, "filter wiped at start");
    tick();
    check_bit(stat.filter_clear, 1'b0, "wipe lasts one cycle");
    repeat (46) tick();
    acs_host_model_inst.set_pin(1'b0);
    repeat (4) tick();
    acs_host_model_inst.set_pin(1'b1);
    t_mark = cyc_now;
    wait_conv();
    check_near(n, le, "restart latency");
    pin_start();
    repeat (20) tick();
    check_bit(stat.busy, 1'b1, "busy while converting");
    check_bit(stat.filter_run, 1'b1, "filter phase after delay");
    acs_host_model_inst.set_pin(1'b0);
    wait_conv();
    check_near(n, le, "pulse stop mid conversion");
    check_bit(stat.busy, 1'b0, "pulse ends idle");
    for (int k = 0; k < 6; k++) begin
      cfg = '{auto_zero: T_AZ[k], filter: T_FILT[k], rate: T_RATE[k], delay: T_DLY[k]};
      pin_start();
      wait_conv();
      check_near(n, lat_exp(T_DLY[k], T_LAT[k], T_AZ[k]), "first latency");
      check_bit(stat.chop_invert, T_AZ[k], "polarity after first result");
    end
    cfg = '{auto_zero: 1'b0, filter: 3'h0, rate: 5'h04, delay: DELAY_DEF_CODE};
    conversion_setup_register = 8'h00;
    pin_start();
    wait_conv();
    check_near(n, le, "continuous first");
    wait_conv();
    check_near(n, cyc(PERIOD_NS[4]), "continuous period");
    repeat (10) tick();
    acs_host_model_inst.set_pin(1'b0);
    wait_conv();
    check_near(n, cyc(PERIOD_NS[4]), "pin stop lets it finish");
    quiet(200);
    check_bit(seen_hi, 1'b0, "idle after pin stop");
    acs_host_model_inst.send_cmd(8'h55);
    quiet(100);
    check_bit(seen_hi, 1'b0, "unknown byte ignored");
    acs_host_model_inst.send_cmd(CMD_START);
    t_mark = cyc_now;
    wait_conv();
    check_near(n, le, "serial start");
    wait_conv();
    check_near(n, cyc(PERIOD_NS[4]), "serial period");
    repeat (10) tick();
    acs_host_model_inst.send_cmd(CMD_STOP);
    wait_conv();
    check_near(n, cyc(PERIOD_NS[4]), "serial stop lets it finish");
    quiet(200);
    check_bit(seen_hi, 1'b0, "idle after serial stop");
    // sinc2 at 20: latency over period is 2, so the host drops 3 results
    cfg = '{auto_zero: 1'b0, filter: 3'h1, rate: 5'h04, delay: DELAY_DEF_CODE};
    pin_start();
    repeat (3) wait_conv();
    wait_conv();
    check_near(n, cyc(PERIOD_NS[4]), "settled result period");
    acs_host_model_inst.set_pin(1'b0);
    wait_conv();
    check_near(n, cyc(PERIOD_NS[4]), "sinc2 stop lets it finish");
    report_and_stop();
  end
endmodule
